// >>> core/ipsc_core.sv
// Per-processor interrupt pending and in-service core with register port.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ipsc_defs.svh"
// Register map, one 32-bit word per address index:
//   0  processor status word; bit 0 is the global interrupt enable bit.
//   1  priority mask register; an 8-bit masking level.
//   2  vector acquire register; a read returns the top unmasked pending vector and
//      moves it to in-service, or returns the spurious code with no side effect.
//   3  service complete register; a write names the vector whose service is done.
//   4-7  pending flags, 32 vectors per word, lowest vectors at index 4.
//   8-11  in-service flags, same layout as the pending words.
//   12  own identifier matched against the destination of bus messages.
//   13  event status: bit 0 reserved-operand fault, bit 1 interrupt received; write one
//       to clear.
//   14  event mask with the status layout; the event line is high while a set status
//       bit is unmasked.
//   15  vector raised by a rising edge on any local pin; reads back the first pin's entry.
// Every bit above a register's field is reserved: it reads as zero, and a write that sets
// one is dropped whole and reported as a fault. Read-only indices take no reserved check.
// Read data stand for exactly one cycle after the read strobe and are zero otherwise.
// Timing: an arrival registered at one edge is pending at the next, and a local pin edge
// needs two more edges to cross the synchroniser. The request line follows pending state
// without a register, so it falls in the cycle after the acquiring read.
// Function
// - Every reserved register field reads back as zero whatever was written.
// - A write with any reserved field non-zero raises a reserved-operand fault to the core.
// - An interrupt is received on an asserted local pin or a bus message carrying our identifier; the core takes only a pin's rising edge.
// - Each vector has one pending flag and repeated arrivals merge into it uncounted.
// - With interrupts enabled and the top pending vector unmasked, the core is told to interrupt.
// - Acquiring a vector clears its pending flag and sets its single in-service flag.
// - A write of the completion register clears the in-service flag of the given vector.
// - External interrupts are enabled only while the global enable bit equals 1.
// - A vector is unmasked only above both the top in-service vector and the mask level.
module ipsc_core #(
  parameter int NPINS = 2
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic [NPINS-1:0] LOCAL_PIN,
  input wire ipsc_pkg::ipsc_msg_t BUS_MSG,
  input wire ipsc_pkg::ipsc_bus_t REG_BUS,
  output logic [31:0] REG_RDATA,
  output logic INT_REQUEST,
  output logic RSVD_FAULT,
  output logic IRQ
);

  localparam int NV = 256;

  logic [NV-1:0] pend_q;
  logic [NV-1:0] serv_q;
  logic gie_q;
  logic [7:0] mask_lvl_q;
  logic [7:0] my_id_q;
  logic [7:0] local_vec_q [NPINS];
  logic [`IPSC_EV_W-1:0] ev_stat_q;
  logic [`IPSC_EV_W-1:0] ev_mask_q;
  logic [31:0] rdata_q;
  logic fault_q;
  logic [NPINS-1:0] pin_s2_q;
  logic [NPINS-1:0] pin_prev_q;
  ipsc_pkg::ipsc_msg_t msg_q;

  logic [7:0] top_pend;
  logic top_pend_v;
  logic [7:0] top_serv;
  logic top_serv_v;
  logic unmasked;
  logic acquire;
  logic complete;
  logic rsvd_bad;
  logic recv_any;
  logic [NV-1:0] arrive;
  logic [3:0] a;
  logic [31:0] wd;
  logic [`IPSC_EV_W-1:0] ev_set;
  logic [`IPSC_EV_W-1:0] ev_clr;

  assign a = REG_BUS.addr;
  assign wd = REG_BUS.wdata;

  // Local pins come from outside the clock domain, so two flops precede any use.
  for (genvar p = 0; p < NPINS; p++) begin : g_pin_sync
    ipsc_sync2 u_sync (
      .clk(SYS_CLK),
      .rst_n(RSTN),
      .en(CLK_EN),
      .d(LOCAL_PIN[p]),
      .q(pin_s2_q[p])
    );
  end

  // The previous synchronised level; it resets low so no false edge follows reset.
  // A pin must be high at one clock edge to be seen; shorter pulses between edges may be lost.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_prev_q <= '0;
    end else if (CLK_EN) begin
      pin_prev_q <= pin_s2_q;
    end
  end

  // Bus messages are registered once; they come from same-clock bus logic.
  // The register costs a cycle but keeps the identifier compare off the bus path.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      msg_q <= '0;
    end else if (CLK_EN) begin
      msg_q <= BUS_MSG;
    end
  end

  // Arrivals: a rising pin edge or a message that names this processor.
  // Two sources naming one vector in one cycle merge into a single arrival.
  // Arrivals are flags, not counts, so nothing is lost by merging.
  always_comb begin
    arrive = '0;
    for (int i = 0; i < NPINS; i++) begin
      if (pin_s2_q[i] && !pin_prev_q[i]) begin
        arrive[local_vec_q[i]] = 1'b1;
      end
    end
    if (msg_q.valid && (msg_q.dest_id == my_id_q)) begin
      arrive[msg_q.vector] = 1'b1;
    end
  end
  assign recv_any = |arrive;

  // Pending and in-service flags share one priority finder design.
  ipsc_top_find #(.N(NV), .W(`IPSC_VEC_W)) u_top_pend (
    .flags(pend_q),
    .top(top_pend),
    .found(top_pend_v)
  );
  ipsc_top_find #(.N(NV), .W(`IPSC_VEC_W)) u_top_serv (
    .flags(serv_q),
    .top(top_serv),
    .found(top_serv_v)
  );

  // Equal priorities do not unmask, so a vector already in service cannot nest on itself.
  // The enable gates only the request line; software may still acquire while disabled.
  // The top pending vector must beat both the in-service level and the mask level.
  assign unmasked = top_pend_v && (!top_serv_v || (top_pend > top_serv))
                    && (top_pend > mask_lvl_q);
  assign INT_REQUEST = gie_q && unmasked;

  // Reserved fields are every bit above the defined width of each register.
  // Read-only indices are not checked, since nothing is ever stored through them.
  always_comb begin
    rsvd_bad = 1'b0;
    if (a == `IPSC_ADDR_STATUS_WORD) begin
      rsvd_bad = |wd[31:1];
    end else if (a == `IPSC_ADDR_PRIO_MASK || a == `IPSC_ADDR_COMPLETE) begin
      rsvd_bad = |wd[31:8];
    end else if (a == `IPSC_ADDR_MY_ID || a == `IPSC_ADDR_LOCAL_VEC) begin
      rsvd_bad = |wd[31:8];
    end else if (a == `IPSC_ADDR_IRQ_STAT || a == `IPSC_ADDR_IRQ_MASK) begin
      rsvd_bad = |wd[31:`IPSC_EV_W];
    end
  end

  // A faulting write is discarded so no reserved bit is ever stored.
  // Dropping the whole word is simpler than merging the legal fields, and safer.
  wire wr_ok = REG_BUS.wr && !rsvd_bad;
  assign acquire = REG_BUS.rd && (a == `IPSC_ADDR_ACQUIRE) && unmasked;
  assign complete = wr_ok && (a == `IPSC_ADDR_COMPLETE);

  // Event causes and write-one-to-clear requests, decoded apart from the flops.
  // A faulting write to the status index clears nothing, since it is dropped whole.
  always_comb begin
    ev_set = '0;
    ev_set[`IPSC_EV_FAULT] = REG_BUS.wr && rsvd_bad;
    ev_set[`IPSC_EV_RECV] = recv_any;
    ev_clr = '0;
    if (wr_ok && (a == `IPSC_ADDR_IRQ_STAT)) begin
      ev_clr = wd[`IPSC_EV_W-1:0];
    end
  end

  // Pending flags: a new arrival wins over the acquire in the same cycle.
  // Clearing by index lets an acquire and an arrival of another vector coexist.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_q <= '0;
    end else if (CLK_EN) begin
      for (int v = 0; v < NV; v++) begin
        if (arrive[v]) begin
          pend_q[v] <= 1'b1;
        end else if (acquire && (top_pend == 8'(v))) begin
          pend_q[v] <= 1'b0;
        end
      end
    end
  end

  // In-service flags: acquire sets, completion of the named vector clears.
  // Completion of a vector not in service is harmless and changes nothing.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      serv_q <= '0;
    end else if (CLK_EN) begin
      for (int v = 0; v < NV; v++) begin
        if (acquire && (top_pend == 8'(v))) begin
          serv_q[v] <= 1'b1;
        end else if (complete && (wd[7:0] == 8'(v))) begin
          serv_q[v] <= 1'b0;
        end
      end
    end
  end

  // Software-written control state.
  // Faulting writes never reach these registers, so reserved bits cannot be stored.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      gie_q <= 1'b0;
      mask_lvl_q <= '0;
      my_id_q <= '0;
      ev_mask_q <= '0;
      for (int i = 0; i < NPINS; i++) begin
        local_vec_q[i] <= '0;
      end
    end else if (CLK_EN && wr_ok) begin
      if (a == `IPSC_ADDR_STATUS_WORD) begin
        gie_q <= wd[`IPSC_GIE_BIT];
      end else if (a == `IPSC_ADDR_PRIO_MASK) begin
        mask_lvl_q <= wd[7:0];
      end else if (a == `IPSC_ADDR_MY_ID) begin
        my_id_q <= wd[7:0];
      end else if (a == `IPSC_ADDR_IRQ_MASK) begin
        ev_mask_q <= wd[`IPSC_EV_W-1:0];
      end else if (a == `IPSC_ADDR_LOCAL_VEC) begin
        // Every pin shares the one written vector; only the first entry reads back.
        for (int i = 0; i < NPINS; i++) begin
          local_vec_q[i] <= wd[7:0];
        end
      end
    end
  end

  // Sticky event status; a set in the clearing cycle wins so no event is lost.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ev_stat_q <= '0;
    end else if (CLK_EN) begin
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
    end
  end

  // Fault pulse for the core's exception reporting, one cycle after the bad write.
  // The pulse is registered so the exception path sees a clean single-cycle level.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fault_q <= 1'b0;
    end else if (CLK_EN) begin
      fault_q <= REG_BUS.wr && rsvd_bad;
    end
  end
  assign RSVD_FAULT = fault_q;
  assign IRQ = |(ev_stat_q & ev_mask_q);

  // Read data: upper bits are always zero, so reserved fields never leak.
  // The word returns to zero after one cycle, so a stale value is never mistaken
  // for a fresh answer.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= '0;
    end else if (CLK_EN) begin
      rdata_q <= '0;
      if (REG_BUS.rd) begin
        if (a == `IPSC_ADDR_STATUS_WORD) begin
          rdata_q <= {31'h0, gie_q};
        end else if (a == `IPSC_ADDR_PRIO_MASK) begin
          rdata_q <= {24'h0, mask_lvl_q};
        end else if (a == `IPSC_ADDR_ACQUIRE) begin
          rdata_q <= {24'h0, unmasked ? top_pend : `IPSC_SPURIOUS};
        end else if (a >= `IPSC_ADDR_PEND_LO && a < `IPSC_ADDR_SERV_LO) begin
          rdata_q <= pend_q[32*(a - `IPSC_ADDR_PEND_LO) +: 32];
        end else if (a >= `IPSC_ADDR_SERV_LO && a < `IPSC_ADDR_MY_ID) begin
          rdata_q <= serv_q[32*(a - `IPSC_ADDR_SERV_LO) +: 32];
        end else if (a == `IPSC_ADDR_MY_ID) begin
          rdata_q <= {24'h0, my_id_q};
        end else if (a == `IPSC_ADDR_IRQ_STAT) begin
          rdata_q <= {30'h0, ev_stat_q};
        end else if (a == `IPSC_ADDR_IRQ_MASK) begin
          rdata_q <= {30'h0, ev_mask_q};
        end else if (a == `IPSC_ADDR_LOCAL_VEC) begin
          rdata_q <= {24'h0, local_vec_q[0]};
        end
      end
    end
  end
  assign REG_RDATA = rdata_q;

endmodule : ipsc_core

// Highest set flag of a vector, found by an upward scan so the last hit wins.
module ipsc_top_find #(
  parameter int N = 256,
  parameter int W = 8
) (
  input wire logic [N-1:0] flags,
  output logic [W-1:0] top,
  output logic found
);
  // The scan is linear and long; it trades clock speed for a very small footprint.
  always_comb begin
    top = '0;
    found = 1'b0;
    for (int v = 0; v < N; v++) begin
      if (flags[v]) begin
        top = W'(v);
        found = 1'b1;
      end
    end
  end
endmodule : ipsc_top_find

// Two-flop synchroniser for one asynchronous pin; only the second flop is read outside.
module ipsc_sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic d,
  output logic q
);
  logic s1_q;
  logic s2_q;
  // Both flops reset to the pin's idle low level, so no false edge follows reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else if (en) begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule : ipsc_sync2

// >>> core/ipsc_defs.svh
// Constant definitions for the interrupt pending and service core.
`ifndef IPSC_DEFS_SVH
`define IPSC_DEFS_SVH
`define IPSC_ADDR_STATUS_WORD 4'h0
`define IPSC_ADDR_PRIO_MASK 4'h1
`define IPSC_ADDR_ACQUIRE 4'h2
`define IPSC_ADDR_COMPLETE 4'h3
`define IPSC_ADDR_PEND_LO 4'h4
`define IPSC_ADDR_SERV_LO 4'h8
`define IPSC_ADDR_MY_ID 4'hC
`define IPSC_ADDR_IRQ_STAT 4'hD
`define IPSC_ADDR_IRQ_MASK 4'hE
`define IPSC_ADDR_LOCAL_VEC 4'hF
`define IPSC_GIE_BIT 0
`define IPSC_VEC_W 8
`define IPSC_SPURIOUS 8'h0F
`define IPSC_EV_FAULT 0
`define IPSC_EV_RECV 1
`define IPSC_EV_W 2
`endif

// >>> core/ipsc_pkg.sv
// Types shared by the interrupt pending and service core.
package ipsc_pkg;
  typedef struct packed {
    logic valid;
    logic [7:0] dest_id;
    logic [7:0] vector;
  } ipsc_msg_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [31:0] wdata;
  } ipsc_bus_t;
endpackage : ipsc_pkg

// >>> verification/ipsc_core_sva.sv
// Port checker for the interrupt pending and service core.
`timescale 1ns/1ps
module ipsc_chk (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire ipsc_pkg::ipsc_bus_t REG_BUS,
  input wire ipsc_pkg::ipsc_msg_t BUS_MSG,
  input wire logic [31:0] REG_RDATA,
  input wire logic INT_REQUEST,
  input wire logic RSVD_FAULT
);
  // Strobes count only on edges that the clock enable lets through.
  wire rd = REG_BUS.rd && CLK_EN;
  wire wr = REG_BUS.wr && CLK_EN;
  wire [3:0] a = REG_BUS.addr;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  a_rdata_quiet: assert property (CLK_EN && !REG_BUS.rd |=> REG_RDATA == 32'h0)
    else $error("read data not idle");
  a_fault_cause: assert property (wr && a == 4'h1 && |REG_BUS.wdata[31:8] |=> RSVD_FAULT)
    else $error("no fault on reserved write");
  a_fault_origin: assert property (RSVD_FAULT |-> $past(wr))
    else $error("fault without write");
  a_word_rsvd: assert property (rd && a == 4'h0 |=> REG_RDATA[31:1] == 31'h0)
    else $error("status word reserved bits set");
  a_mask_rsvd: assert property (rd && a == 4'h1 |=> REG_RDATA[31:8] == 24'h0)
    else $error("mask reserved bits set");
  a_gie_off: assert property (wr && a == 4'h0 && REG_BUS.wdata == 32'h0 |=> !INT_REQUEST)
    else $error("request while disabled");
  a_mask_full: assert property (wr && a == 4'h1 && REG_BUS.wdata == 32'hFF |=> !INT_REQUEST)
    else $error("request above full mask");
  // A message in flight could pend a higher vector, so those cycles are left out.
  a_take_top: assert property (rd && a == 4'h2 && INT_REQUEST && !BUS_MSG.valid &&
    !$past(BUS_MSG.valid) |=> !INT_REQUEST)
    else $error("request after acquire");
  c_fault: cover property (RSVD_FAULT);
  c_acquire: cover property (rd && a == 4'h2 && INT_REQUEST);
  c_drop: cover property (INT_REQUEST ##1 !INT_REQUEST);
endmodule : ipsc_chk
bind ipsc_core ipsc_chk u_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN),
  .REG_BUS(REG_BUS), .BUS_MSG(BUS_MSG), .REG_RDATA(REG_RDATA), .INT_REQUEST(INT_REQUEST),
  .RSVD_FAULT(RSVD_FAULT));

// >>> verification/ipsc_msg_src.sv
// System bus model that issues interrupt messages.
`timescale 1ns/1ps
module ipsc_msg_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic send,
  input wire logic [7:0] dest,
  input wire logic [7:0] vec,
  output ipsc_pkg::ipsc_msg_t msg
);
  // Idle fields toggle so that a stale message can never pass for a live one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msg <= '0;
    end else begin
      msg.valid <= send;
      msg.dest_id <= send ? dest : ~msg.dest_id;
      msg.vector <= send ? vec : ~msg.vector;
    end
  end
endmodule : ipsc_msg_src

// >>> verification/tb_interrupt_pending_service_core.sv
// Self-checking testbench of the interrupt pending and service core.
`timescale 1ns/1ps
module tb_interrupt_pending_service_core;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  ipsc_pkg::ipsc_bus_t bus = '0;
  ipsc_pkg::ipsc_msg_t msg_w;
  logic [1:0] pin = 2'h0;
  logic snd = 1'b0;
  logic ce = 1'b1;
  logic [7:0] did = 8'h0, vec = 8'h0, v1, v2;
  logic was_rd = 1'b0, was_wr = 1'b0, req, fault, irq;
  logic [31:0] rdata;
  logic [31:0] exp_q[$];
  int miscompares = 0, num_checks = 0;
  ipsc_msg_src u_src (.clk(sys_clk), .rst_n(rst_n), .send(snd), .dest(did), .vec(vec),
    .msg(msg_w));
  ipsc_core #(.NPINS(2)) DUT (.SYS_CLK(sys_clk), .RSTN(rst_n), .CLK_EN(ce), .LOCAL_PIN(pin),
    .BUS_MSG(msg_w), .REG_BUS(bus), .REG_RDATA(rdata), .INT_REQUEST(req), .RSVD_FAULT(fault),
    .IRQ(irq));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // Every read or write cycle notes its expected read data or fault flag for the monitor.
  task automatic op(input logic r, w, input logic [3:0] a, input logic [31:0] d, e);
    bus <= '{r, w, a, d};
    snd <= 1'b0;
    if (r || w) exp_q.push_back(e);
    @(posedge sys_clk);
  endtask : op
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    op(1'b1, 1'b0, a, 32'h0, e);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic f);
    op(1'b0, 1'b1, a, d, {31'h0, f});
  endtask : wr
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 4'h0, 32'h0, 32'h0);
  endtask : idle
  task automatic send_msg(input logic [7:0] id, v);
    bus <= '0;
    {snd, did, vec} <= {1'b1, id, v};
    @(posedge sys_clk);
  endtask : send_msg
  // Levels are looked at mid-cycle after two idle edges, once every register has settled.
  task automatic lvl(input logic r, i);
    idle(2);
    @(negedge sys_clk);
    check("int_request", {31'h0, req}, {31'h0, r});
    check("irq", {31'h0, irq}, {31'h0, i});
    @(posedge sys_clk);
  endtask : lvl
  // Answers stand one cycle, so the oldest note is taken at the edge that ends them.
  always @(posedge sys_clk) begin
    if (was_rd) check("rdata", rdata, exp_q.pop_front());
    if (was_wr) check("fault", {31'h0, fault}, exp_q.pop_front());
    was_rd <= bus.rd;
    was_wr <= bus.wr;
  end
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hB7E0745B));
    v1 = 8'h20 + 8'($urandom_range(31));
    v2 = v1 + 8'h40;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    wr(4'hC, 32'h5, 1'b0);
    wr(4'h0, 32'h1, 1'b0);
    send_msg(8'h5, 8'h40);
    send_msg(8'h5, 8'h40);
    send_msg(8'h6, 8'h50);
    lvl(1'b1, 1'b0);
    rd(4'h6, 32'h1);
    rd(4'h2, 32'h40);
    rd(4'h6, 32'h0);
    rd(4'hA, 32'h1);
    rd(4'h2, 32'hF);
    wr(4'h3, 32'h40, 1'b0);
    rd(4'hA, 32'h0);
    wr(4'h1, 32'h10, 1'b0);
    send_msg(8'h5, v1);
    send_msg(8'h5, v2);
    idle(5);
    rd(4'h2, {24'h0, v2});
    lvl(1'b0, 1'b0);
    rd(4'h2, 32'hF);
    wr(4'h3, {24'h0, v2}, 1'b0);
    lvl(1'b1, 1'b0);
    wr(4'h1, 32'hFF, 1'b0);
    lvl(1'b0, 1'b0);
    wr(4'h1, 32'h0, 1'b0);
    wr(4'h0, 32'h0, 1'b0);
    lvl(1'b0, 1'b0);
    wr(4'h0, 32'h1, 1'b0);
    lvl(1'b1, 1'b0);
    rd(4'h2, {24'h0, v1});
    wr(4'h3, {24'h0, v1}, 1'b0);
    wr(4'h1, 32'h100, 1'b1);
    rd(4'h1, 32'h0);
    wr(4'h0, 32'hFFFFFFFF, 1'b1);
    rd(4'h0, 32'h1);
    wr(4'hE, 32'h1, 1'b0);
    lvl(1'b0, 1'b1);
    wr(4'hD, 32'h1, 1'b0);
    lvl(1'b0, 1'b0);
    rd(4'hD, 32'h2);
    wr(4'hF, 32'h70, 1'b0);
    pin <= 2'h1;
    idle(5);
    rd(4'h2, 32'h70);
    wr(4'h3, 32'h70, 1'b0);
    pin <= 2'h2;
    idle(5);
    rd(4'h2, 32'h70);
    wr(4'h3, 32'h70, 1'b0);
    // A write while the clock enable is low must leave the mask untouched.
    ce <= 1'b0;
    wr(4'h1, 32'h33, 1'b0);
    ce <= 1'b1;
    rd(4'h1, 32'h0);
    idle(3);
    report_and_stop();
  end
endmodule : tb_interrupt_pending_service_core
